/* File: pkg/tsc_pkg.sv */
/*
 * Shared constants and carrier types for the test snapshot and
 * configuration load block.
 * Assumes a single 40 MHz system clock domain.
 */
package tsc_pkg;

    // Pin image size and byte positions
    localparam int SNAP_BYTES = 4;
    localparam logic [7:0] LAST_MAPPED = 8'h03;
    localparam int B0_RESET = 7;
    localparam int B0_CS_LO = 4;
    localparam int B0_PWRVLD = 3;
    localparam int B0_DA_LO = 1;
    localparam int B1_DD_DRIVE = 7;
    localparam int B1_DIOR = 1;
    localparam int B1_DMACK = 2;
    localparam int B1_DIOW = 0;

    // Configuration table
    localparam logic [7:0] SIG0_VALUE = 8'h53;
    localparam logic [7:0] SIG1_VALUE = 8'h4B;
    localparam logic [7:0] CFG_SIG0_ADDR = 8'h00;
    localparam logic [7:0] CFG_SIG1_ADDR = 8'h01;
    localparam logic [7:0] CFG_APM_ADDR = 8'h02;
    localparam logic [7:0] CFG_MARKER_ADDR = 8'h04;
    localparam logic [7:0] CFG_FLAGS_ADDR = 8'h05;
    localparam logic [7:0] CFG_LAST_ADDR = 8'h05;
    localparam int CFG_PAGE8_BIT = 5;
    localparam logic [7:0] APM_OFF = 8'h00;
    localparam logic [7:0] MARKER_DEFAULT = 8'h24;

    // Memory device addresses, first and fallback
    localparam logic [2:0] MEM_ADDR_FIRST = 3'h2;
    localparam logic [2:0] MEM_ADDR_ALT = 3'h4;

    // Reset values and counts
    localparam logic [31:0] LOAD_RESET = 32'h0000_0000;
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    // Raw ATA-side pin levels, as seen on the pads
    typedef struct packed {
        logic reset_line;
        logic da2;
        logic [1:0] cs_n;
        logic drive_power_valid;
        logic [1:0] da;
        logic intrq;
        logic mfg_sel;
        logic ata_bus_power_enable;
        logic dmarq;
        logic iordy;
        logic dmack_n;
        logic dior_n;
        logic diow_n;
        logic [15:0] dd;
    } tsc_pin_in_t;

    // Controllable ATA-side outputs; dd_oe_n low drives the data bus
    typedef struct packed {
        logic reset_line;
        logic [1:0] cs_n;
        logic drive_power_valid;
        logic [1:0] da;
        logic dmack_n;
        logic dior_n;
        logic diow_n;
        logic [15:0] dd;
        logic dd_oe_n;
    } tsc_pin_out_t;

    // Fetched configuration bytes
    typedef struct packed {
        logic [7:0] drive_power_mgmt_value;
        logic [7:0] marker;
        logic [7:0] flags;
    } tsc_cfg_t;

endpackage

/* File: logic/tsc_cfg_fetch.sv */
/*
 * Startup fetch of the first configuration bytes through an external
 * byte-read engine, with signature check and address fallback.
 * Assumes the read engine runs on the same clock and answers each
 * one-cycle request with a one-cycle done pulse at least a cycle later.
 */
`timescale 1ns/1ps
module tsc_cfg_fetch (
    input wire logic clk,
    input wire logic rst_n,
    output logic i2c_req,
    output logic [2:0] i2c_dev_addr,
    output logic [7:0] i2c_byte_addr,
    input wire logic i2c_done,
    input wire logic i2c_ack,
    input wire logic [7:0] i2c_data,
    output tsc_pkg::tsc_cfg_t cfg,
    output logic cfg_ready,
    output logic cfg_valid
);
    typedef enum logic [1:0] {TSC_REQ, TSC_WAIT, TSC_DONE} tsc_fetch_t;

    tsc_fetch_t state;
    logic [7:0] mem [6];
    logic sig_ok;

    assign sig_ok = mem[0] == tsc_pkg::SIG0_VALUE &&
                    mem[1] == tsc_pkg::SIG1_VALUE;

    // Fetch sequencer; a refusal at the first byte retries the alt address
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= TSC_REQ;
            i2c_req <= 1'b0;
            i2c_dev_addr <= tsc_pkg::MEM_ADDR_FIRST;
            i2c_byte_addr <= tsc_pkg::CFG_SIG0_ADDR;
            cfg_ready <= 1'b0;
        end else begin
            i2c_req <= 1'b0;
            case (state)
                TSC_REQ: begin
                    i2c_req <= 1'b1;
                    state <= TSC_WAIT;
                end
                TSC_WAIT: begin
                    if (i2c_done && !i2c_ack) begin
                        if (i2c_byte_addr == tsc_pkg::CFG_SIG0_ADDR &&
                            i2c_dev_addr == tsc_pkg::MEM_ADDR_FIRST) begin
                            i2c_dev_addr <= tsc_pkg::MEM_ADDR_ALT;
                            state <= TSC_REQ;
                        end else begin
                            state <= TSC_DONE;
                            cfg_ready <= 1'b1;
                        end
                    end else if (i2c_done) begin
                        if (i2c_byte_addr == tsc_pkg::CFG_LAST_ADDR) begin
                            state <= TSC_DONE;
                            cfg_ready <= 1'b1;
                        end else begin
                            i2c_byte_addr <= i2c_byte_addr + 8'h01;
                            state <= TSC_REQ;
                        end
                    end
                end
                TSC_DONE: state <= TSC_DONE;
                default: state <= TSC_REQ;
            endcase
        end
    end

    // Byte store
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 6; i++) begin
                mem[i] <= 8'h00;
            end
        end else if (state == TSC_WAIT && i2c_done && i2c_ack) begin
            mem[i2c_byte_addr[2:0]] <= i2c_data;
        end
    end

    // Published result, latched once the fetch ends
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_valid <= 1'b0;
            cfg <= '0;
        end else if (state != TSC_DONE && cfg_ready == 1'b0) begin
            cfg_valid <= 1'b0;
        end else if (state == TSC_DONE && !cfg_valid && sig_ok) begin
            cfg_valid <= 1'b1;
            cfg.drive_power_mgmt_value <= mem[2];
            cfg.marker <= mem[4];
            cfg.flags <= mem[5];
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence first_refused_s;
        i2c_done && !i2c_ack && state == TSC_WAIT &&
        i2c_byte_addr == tsc_pkg::CFG_SIG0_ADDR &&
        i2c_dev_addr == tsc_pkg::MEM_ADDR_FIRST;
    endsequence

    sequence retry_alt_s;
        i2c_req && i2c_dev_addr == tsc_pkg::MEM_ADDR_ALT &&
        i2c_byte_addr == tsc_pkg::CFG_SIG0_ADDR;
    endsequence

    addr_fallback_a: assert property (
        first_refused_s |-> ##2 retry_alt_s)
        else $error("no retry at the alternate memory address");

    sig_check_a: assert property (
        $rose(cfg_valid) |-> mem[0] == 8'h53 && mem[1] == 8'h4B)
        else $error("configuration accepted without signature");

    dev_addr_legal_a: assert property (
        i2c_req |-> i2c_dev_addr inside {3'h2, 3'h4})
        else $error("memory addressed outside its two addresses");

endmodule

/* File: logic/tsc_mfg_test.sv */
/*
 * Manufacturing test pin snapshot and pin load path of the bridge, plus
 * the use of the fetched configuration bytes.
 * Assumes pad inputs are asynchronous; the command, byte-read engine and
 * drive-init handshakes are on sys_clk.
 */
// What this block does
// - In test mode, a snapshot request samples the non-USB input pins.
// - Only four response bytes hold pin data; any length is accepted.
// - Byte 0 maps reset, DA2, chip selects, power valid, DA1..0, INTRQ.
// - Byte 1 bit 7 drives or floats data bus; bytes 2, 3 data.
// - Byte 1 bit 6 reports the mode-select input, read only.
// - The configuration memory is addressed at address 2 or 4.
// - Configuration is valid only with signature 0x53 then 0x4B.
// - Nonzero power value enables drive power management at init.
// - A command block starting with the marker byte is vendor specific.
// - Flags byte bit 5 enables the write-caching mode page.
// - A pin load enters test mode; loaded bytes drive the pins.
// - Reset line low at power-up starts board test mode.
`timescale 1ns/1ps
module tsc_mfg_test (
    input wire logic sys_clk,
    input wire logic arst_n,
    input tsc_pkg::tsc_pin_in_t pin_in,
    input tsc_pkg::tsc_pin_out_t norm_out,
    output tsc_pkg::tsc_pin_out_t pin_out,
    output logic mfg_mode,
    output logic pin_ctl,
    input wire logic snap_req,
    input wire logic rd_req,
    input wire logic [7:0] rd_idx,
    output logic rd_valid,
    output logic [7:0] rd_data,
    input wire logic ld_valid,
    input wire logic [7:0] ld_idx,
    input wire logic [7:0] ld_data,
    output logic i2c_req,
    output logic [2:0] i2c_dev_addr,
    output logic [7:0] i2c_byte_addr,
    input wire logic i2c_done,
    input wire logic i2c_ack,
    input wire logic [7:0] i2c_data,
    output logic cfg_ready,
    output logic cfg_valid,
    input wire logic cbw_valid,
    input wire logic [7:0] cbw_byte0,
    output logic vendor_valid,
    output logic vendor_cmd,
    input wire logic init_req,
    input wire logic dev_is_atapi,
    input wire logic dev_apm_cap,
    output logic setf_req,
    output logic [7:0] setf_value,
    output logic page8_en
);
    logic rst_s1;
    logic rst_n;
    tsc_pkg::tsc_pin_in_t pin_s1;
    tsc_pkg::tsc_pin_in_t pin_s2;
    logic [31:0] snap;
    logic [31:0] next_snap;
    logic [31:0] ld_img;
    logic [1:0] strap_cnt;
    logic strap_done;
    tsc_pkg::tsc_cfg_t cfg;
    logic [7:0] marker;

    // Pick one image byte; anything past the mapped four reads as zero
    function automatic logic [7:0] pick_byte(input logic [31:0] img,
                                             input logic [7:0] idx);
        logic [7:0] b;
        b = 8'h00;
        if (idx <= tsc_pkg::LAST_MAPPED) begin
            b = img[{idx[1:0], 3'b000} +: 8];
        end
        return b;
    endfunction

    // Reset release through two flip-flops
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // Pad inputs pass two flip-flops; all levels, reset line included, reset low
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else begin
            pin_s1 <= pin_in;
            pin_s2 <= pin_s1;
        end
    end

    // Image of the current pin levels in snapshot layout
    always_comb begin
        next_snap = {pin_s2.dd[15:8], pin_s2.dd[7:0],
                     1'b0, pin_s2.mfg_sel,
                     pin_s2.ata_bus_power_enable, pin_s2.dmarq,
                     pin_s2.iordy, pin_s2.dmack_n, pin_s2.dior_n,
                     pin_s2.diow_n,
                     pin_s2.reset_line, pin_s2.da2, pin_s2.cs_n,
                     pin_s2.drive_power_valid, pin_s2.da,
                     pin_s2.intrq};
    end

    // Snapshot taken on request, only while in test mode
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            snap <= 32'h0000_0000;
        end else if (snap_req && mfg_mode) begin
            snap <= next_snap;
        end
    end

    // Read answer one cycle after the request, any index accepted
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid <= 1'b0;
            rd_data <= 8'h00;
        end else begin
            rd_valid <= rd_req;
            if (rd_req) begin
                rd_data <= pick_byte(snap, rd_idx);
            end
        end
    end

    // Load image, one byte register per mapped byte
    genvar g;
    generate
        for (g = 0; g < tsc_pkg::SNAP_BYTES; g++) begin : gen_ld
            logic [7:0] b;
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    b <= tsc_pkg::LOAD_RESET[g*8 +: 8];
                end else if (ld_valid && ld_idx == 8'(g)) begin
                    b <= ld_data;
                end
            end
            assign ld_img[g*8 +: 8] = b;
        end
    endgenerate

    // Power-up strap: wait for the synchroniser, then sample once
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt <= 2'h0;
            strap_done <= 1'b0;
        end else if (!strap_done) begin
            strap_cnt <= strap_cnt + 2'h1;
            strap_done <= strap_cnt == tsc_pkg::STRAP_WAIT;
        end
    end

    // Test mode is left only by a hard reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mfg_mode <= 1'b0;
            pin_ctl <= 1'b0;
        end else begin
            if (ld_valid) begin
                mfg_mode <= 1'b1;
                pin_ctl <= 1'b1;
            end
            if (!strap_done && strap_cnt == tsc_pkg::STRAP_WAIT &&
                !pin_s2.reset_line) begin
                mfg_mode <= 1'b1;
            end
        end
    end

    // Output pins: loaded image under pin control, else normal logic
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out <= '0;
            pin_out.reset_line <= 1'b1;
            pin_out.dd_oe_n <= 1'b1;
        end else if (pin_ctl) begin
            pin_out.reset_line <= ld_img[tsc_pkg::B0_RESET];
            pin_out.cs_n <= ld_img[tsc_pkg::B0_CS_LO +: 2];
            pin_out.drive_power_valid <= ld_img[tsc_pkg::B0_PWRVLD];
            pin_out.da <= ld_img[tsc_pkg::B0_DA_LO +: 2];
            pin_out.dmack_n <= ld_img[8 + tsc_pkg::B1_DMACK];
            pin_out.dior_n <= ld_img[8 + tsc_pkg::B1_DIOR];
            pin_out.diow_n <= ld_img[8 + tsc_pkg::B1_DIOW];
            pin_out.dd <= ld_img[31:16];
            pin_out.dd_oe_n <= !ld_img[8 + tsc_pkg::B1_DD_DRIVE];
        end else begin
            pin_out <= norm_out;
        end
    end

    tsc_cfg_fetch tsc_cfg_fetch_inst (
        .clk(sys_clk),
        .rst_n(rst_n),
        .i2c_req(i2c_req),
        .i2c_dev_addr(i2c_dev_addr),
        .i2c_byte_addr(i2c_byte_addr),
        .i2c_done(i2c_done),
        .i2c_ack(i2c_ack),
        .i2c_data(i2c_data),
        .cfg(cfg),
        .cfg_ready(cfg_ready),
        .cfg_valid(cfg_valid)
    );

    // Marker falls back to its default when the table is not valid
    assign marker = cfg_valid ? cfg.marker : tsc_pkg::MARKER_DEFAULT;

    // Vendor command detection on the first command-block byte
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            vendor_valid <= 1'b0;
            vendor_cmd <= 1'b0;
        end else begin
            vendor_valid <= cbw_valid;
            if (cbw_valid) begin
                vendor_cmd <= cbw_byte0 == marker;
            end
        end
    end

    // Power management enable issued during drive initialisation
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            setf_req <= 1'b0;
            setf_value <= 8'h00;
        end else begin
            setf_req <= init_req && cfg_valid && !dev_is_atapi &&
                        dev_apm_cap && cfg.drive_power_mgmt_value != tsc_pkg::APM_OFF;
            if (init_req) begin
                setf_value <= cfg.drive_power_mgmt_value;
            end
        end
    end

    // Mode page 8 reporting enable
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            page8_en <= 1'b0;
        end else begin
            page8_en <= cfg_valid && cfg.flags[tsc_pkg::CFG_PAGE8_BIT];
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Snapshot, two quiet cycles, then a read of byte 1
    sequence snap_then_read_s;
        snap_req && mfg_mode ##1 !snap_req [*2] ##1
            rd_req && rd_idx == 8'h01;
    endsequence

    snap_sample_a: assert property (
        snap_req && mfg_mode |=> snap == $past(next_snap))
        else $error("snapshot does not hold the sampled pins");

    read_tail_a: assert property (
        rd_req && rd_idx > 8'h03 |=> rd_valid && rd_data == 8'h00)
        else $error("byte past the fourth is not zero");

    read_byte_a: assert property (
        rd_req && rd_idx < 8'h04 |=>
            rd_valid && rd_data == pick_byte($past(snap), $past(rd_idx)))
        else $error("read byte does not match snapshot");

    mode_sel_a: assert property (
        snap_then_read_s |=> rd_data[6] == $past(pin_s2.mfg_sel, 4))
        else $error("mode-select bit misreported");

    load_enter_a: assert property (
        ld_valid |=> mfg_mode && pin_ctl)
        else $error("load did not enter test mode");

    mode_sticky_a: assert property (
        mfg_mode |=> mfg_mode)
        else $error("test mode left without hard reset");

    dd_float_a: assert property (
        pin_ctl && !ld_img[15] |=> pin_out.dd_oe_n)
        else $error("data bus driven while floated by load");

    pins_follow_a: assert property (
        pin_ctl |=> pin_out.cs_n == $past(ld_img[5:4]) &&
                    pin_out.reset_line == $past(ld_img[7]))
        else $error("loaded byte 0 not on pins");

    vendor_match_a: assert property (
        cbw_valid |=> vendor_cmd == ($past(cbw_byte0) == $past(marker)))
        else $error("vendor command decode wrong");

    apm_use_a: assert property (
        setf_req |-> $past(cfg.drive_power_mgmt_value) != 8'h00 && !$past(dev_is_atapi) &&
                     setf_value == $past(cfg.drive_power_mgmt_value))
        else $error("power management issued when unused");

    page8_a: assert property (
        page8_en |-> cfg_valid && cfg.flags[5])
        else $error("page 8 enabled without flag");

endmodule

/* File: tb/tsc_mem_model.sv */
/*
 * Behavioural configuration memory seen through the byte-read engine.
 * Assumes one request at a time, on the same clock as the block.
 */
`timescale 1ns/1ps
module tsc_mem_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic i2c_req,
    input wire logic [2:0] i2c_dev_addr,
    input wire logic [7:0] i2c_byte_addr,
    input wire logic nack_first,
    input wire logic bad_sig,
    output logic i2c_done,
    output logic i2c_ack,
    output logic [7:0] i2c_data,
    output logic saw_alt,
    output logic bad_addr
);
    logic [7:0] mem [0:255];
    logic busy;
    logic slow;
    logic nak;
    logic [1:0] wait_cnt;
    logic [7:0] adr;

    // Table contents; the reserved byte is kept zero
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'hFF;
        end
        mem[0] = 8'h53;
        mem[1] = 8'h4B;
        mem[2] = 8'h80;
        mem[3] = 8'h00;
        mem[4] = 8'h3C;
        mem[5] = 8'h27;
    end

    // Alternates prompt and slow answers; data churns while idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            slow <= 1'b0;
            nak <= 1'b0;
            wait_cnt <= 2'h0;
            adr <= 8'h00;
            i2c_done <= 1'b0;
            i2c_ack <= 1'b0;
            i2c_data <= 8'h00;
            saw_alt <= 1'b0;
            bad_addr <= 1'b0;
        end else begin
            i2c_done <= 1'b0;
            i2c_data <= ~i2c_data;
            if (i2c_req && !busy) begin
                busy <= 1'b1;
                slow <= ~slow;
                wait_cnt <= slow ? 2'h3 : 2'h0;
                adr <= i2c_byte_addr;
                nak <= nack_first && i2c_dev_addr == 3'h2;
                saw_alt <= saw_alt | (i2c_dev_addr == 3'h4);
                bad_addr <= bad_addr | (i2c_dev_addr != 3'h2 &&
                    i2c_dev_addr != 3'h4);
            end else if (busy && wait_cnt != 2'h0) begin
                wait_cnt <= wait_cnt - 2'h1;
            end else if (busy) begin
                busy <= 1'b0;
                i2c_done <= 1'b1;
                i2c_ack <= !nak;
                if (!nak) begin
                    i2c_data <= (bad_sig && adr == 8'h00) ? 8'h00 : mem[adr];
                end
            end
        end
    end
endmodule

/* File: tb/tsc_mfg_test_bench.sv */
/*
 * Self-checking bench for the test snapshot and configuration block.
 * Assumes the memory model answers the block's byte-read requests.
 */
`timescale 1ns/1ps
module tsc_mfg_test_bench;
    logic sys_clk, arst_n, mfg_mode, pin_ctl, snap_req, rd_req, rd_valid;
    logic ld_valid, i2c_req, i2c_done, i2c_ack, cfg_ready, cfg_valid;
    logic cbw_valid, vendor_valid, vendor_cmd, init_req, dev_is_atapi;
    logic dev_apm_cap, setf_req, page8_en, nack_first, bad_sig, saw_alt;
    logic bad_addr, seen;
    logic [7:0] rd_idx, rd_data, ld_idx, ld_data, i2c_byte_addr, i2c_data;
    logic [7:0] cbw_byte0, setf_value;
    logic [2:0] i2c_dev_addr;
    logic [7:0] img [0:3];
    tsc_pkg::tsc_pin_in_t pin_in;
    tsc_pkg::tsc_pin_out_t norm_out, pin_out, e;
    int bad_count, checks_done;

    tsc_mfg_test tsc_mfg_test_inst (.sys_clk, .arst_n, .pin_in, .norm_out,
        .pin_out, .mfg_mode, .pin_ctl, .snap_req, .rd_req, .rd_idx,
        .rd_valid, .rd_data, .ld_valid, .ld_idx, .ld_data, .i2c_req,
        .i2c_dev_addr, .i2c_byte_addr, .i2c_done, .i2c_ack, .i2c_data,
        .cfg_ready, .cfg_valid, .cbw_valid, .cbw_byte0, .vendor_valid,
        .vendor_cmd, .init_req, .dev_is_atapi, .dev_apm_cap, .setf_req,
        .setf_value, .page8_en);
    tsc_mem_model tsc_mem_model_inst (.clk(sys_clk), .rst_n(arst_n),
        .i2c_req, .i2c_dev_addr, .i2c_byte_addr, .nack_first, .bad_sig,
        .i2c_done, .i2c_ack, .i2c_data, .saw_alt, .bad_addr);

    // Clock at 40 MHz
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // Compares one value and counts the outcome
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Looks for a one-cycle answer: 0 read, 1 vendor, 2 set-features
    task automatic wait_pulse(input int sel);
        seen = 1'b0;
        repeat (4) begin
            #1;
            if ((sel == 0 && rd_valid === 1'b1) ||
                (sel == 1 && vendor_valid === 1'b1) ||
                (sel == 2 && setf_req === 1'b1)) begin
                seen = 1'b1;
                break;
            end
            @(posedge sys_clk);
        end
    endtask

    // Hard reset with the reset line strapped or not, then fetch wait
    task automatic do_reset(input logic strap);
        @(posedge sys_clk);
        arst_n <= 1'b0;
        pin_in.reset_line <= ~strap;
        repeat (10) @(posedge sys_clk);
        chk("reset pin drive", 32'h1, pin_out.reset_line);
        chk("reset float", 32'h1, pin_out.dd_oe_n);
        chk("reset mode", 32'h0, mfg_mode);
        arst_n <= 1'b1;
        for (int i = 0; i < 400 && cfg_ready !== 1'b1; i++) begin
            @(posedge sys_clk);
        end
        if (cfg_ready !== 1'b1) begin
            bad_count++;
            $display("MISMATCH cfg_ready expected 1 seen %b", cfg_ready);
            end_of_test();
        end
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        @(posedge sys_clk);
        rd_req <= 1'b1;
        rd_idx <= idx;
        @(posedge sys_clk);
        rd_req <= 1'b0;
        wait_pulse(0);
        chk("rd_valid", 32'h1, seen);
        chk("rd_data", {24'h0, exp}, {24'h0, rd_data});
    endtask

    task automatic snap();
        repeat (4) @(posedge sys_clk);
        snap_req <= 1'b1;
        @(posedge sys_clk);
        snap_req <= 1'b0;
        @(posedge sys_clk);
    endtask

    function automatic logic [7:0] sbyte(input int k);
        case (k)
            0: return {pin_in.reset_line, pin_in.da2, pin_in.cs_n,
                       pin_in.drive_power_valid, pin_in.da, pin_in.intrq};
            1: return {1'b0, pin_in.mfg_sel, pin_in.ata_bus_power_enable,
                       pin_in.dmarq, pin_in.iordy, pin_in.dmack_n,
                       pin_in.dior_n, pin_in.diow_n};
            2: return pin_in.dd[7:0];
            3: return pin_in.dd[15:8];
            default: return 8'h00;
        endcase
    endfunction

    task automatic vendor(input logic [7:0] b, input logic exp);
        @(posedge sys_clk);
        cbw_valid <= 1'b1;
        cbw_byte0 <= b;
        @(posedge sys_clk);
        cbw_valid <= 1'b0;
        wait_pulse(1);
        chk("vendor_valid", 32'h1, seen);
        chk("vendor_cmd", {31'h0, exp}, {31'h0, vendor_cmd});
    endtask

    task automatic init(input logic atapi, input logic cap, input logic exp);
        @(posedge sys_clk);
        init_req <= 1'b1;
        dev_is_atapi <= atapi;
        dev_apm_cap <= cap;
        @(posedge sys_clk);
        init_req <= 1'b0;
        wait_pulse(2);
        chk("setf_req", {31'h0, exp}, {31'h0, seen});
        if (exp) begin
            chk("setf_value", 32'h80, {24'h0, setf_value});
        end
    endtask

    // Loads the image back to back plus one byte past the mapped four
    task automatic load_check();
        for (int i = 0; i < 5; i++) begin
            @(posedge sys_clk);
            ld_valid <= 1'b1;
            ld_idx <= (i == 4) ? 8'h05 : 8'(i);
            ld_data <= (i == 4) ? 8'hFF : img[i];
        end
        @(posedge sys_clk);
        ld_valid <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk("mfg_mode", 32'h1, mfg_mode);
        chk("pin_ctl", 32'h1, pin_ctl);
        e = norm_out;
        {e.reset_line, e.cs_n, e.drive_power_valid, e.da} =
            {img[0][7], img[0][5:1]};
        e.dd_oe_n = ~img[1][7];
        {e.dmack_n, e.dior_n, e.diow_n} = img[1][2:0];
        e.dd = {img[3], img[2]};
        chk("pin_out", {6'h0, e}, {6'h0, pin_out});
    endtask

    initial begin
        bad_count = 0;
        checks_done = 0;
        arst_n = 1'b0;
        pin_in = '0;
        norm_out = '0;
        {snap_req, rd_req, ld_valid, cbw_valid, init_req} = 5'h00;
        {rd_idx, ld_idx, ld_data, cbw_byte0} = 32'h0000_0000;
        {dev_is_atapi, dev_apm_cap, nack_first, bad_sig} = 4'h0;
        do_reset(1'b0);
        chk("saw_alt", 32'h0, saw_alt);
        chk("cfg_valid", 32'h1, cfg_valid);
        chk("page8_en", 32'h1, page8_en);
        chk("no strap mode", 32'h0, mfg_mode);
        vendor(8'h3C, 1'b1);
        vendor(8'h24, 1'b0);
        init(1'b0, 1'b1, 1'b1);
        init(1'b1, 1'b1, 1'b0);
        init(1'b0, 1'b0, 1'b0);
        pin_in.dd <= 16'hA55A;
        snap();
        rd(8'h02, 8'h00);
        img = '{8'h9A, 8'h85, 8'h3C, 8'hC3};
        load_check();
        img[1] = 8'h05;
        load_check();
        norm_out <= '1;
        repeat (4) @(posedge sys_clk);
        chk("pin_out held", {6'h0, e}, {6'h0, pin_out});
        pin_in <= 31'h2B5A_C3E1;
        snap();
        for (int k = 0; k < 4; k++) begin
            rd(8'(k), sbyte(k));
        end
        rd(8'h04, 8'h00);
        rd(8'hFF, 8'h00);
        nack_first <= 1'b1;
        bad_sig <= 1'b1;
        do_reset(1'b1);
        chk("strap mode", 32'h1, mfg_mode);
        chk("strap pin_ctl", 32'h0, pin_ctl);
        chk("saw_alt", 32'h1, saw_alt);
        chk("bad_addr", 32'h0, bad_addr);
        chk("cfg_valid", 32'h0, cfg_valid);
        chk("page8_en", 32'h0, page8_en);
        vendor(8'h24, 1'b1);
        init(1'b0, 1'b1, 1'b0);
        pin_in.mfg_sel <= 1'b1;
        snap();
        rd(8'h01, sbyte(1));
        end_of_test();
    end
endmodule
